// ---- sensor_irq_clear_and_ir_select.sv ----
// Sensor register target on I2C with infrared routing and interrupt command registers
`timescale 1ns/1ps
`include "sensor_irq_consts.svh"
module sensor_irq_clear_and_ir_select #(
  parameter bit ADDR_VARIANT_B = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_n_o,
  output logic int_n_oe_o,
  input wire logic sample_valid_i,
  input wire sensor_irq_pkg::sample_t sample_i,
  output logic converter_enable_o
);
  logic scl_m_q, scl_q, scl_p_q, sda_m_q, sda_q, sda_p_q;
  logic start_w, stop_w, rise_w, fall_w;
  sensor_irq_pkg::bus_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q, ptr_q, rdata_q;
  logic rw_q, sda_drv_q, got_reg_q;
  logic [7:0] ir_sel_q, enable_q, persist_q, aux_q;
  logic [15:0] thr_low_q, thr_high_q, clear_data_q;
  logic [7:0] shadow_q;
  logic [5:0] out_cnt_q;
  logic sat_q, thr_irq_q, force_q, valid_q;
  logic wr_stb_w;
  logic [7:0] wr_addr_w;
  logic [15:0] chan_w;
  logic out_range_w, thr_event_w;
  logic [6:0] own_addr_w;

  // Two-stage synchronisers on the bus pins, third stage for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      scl_m_q <= 1'b1;
      scl_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en_i) begin
      scl_m_q <= scl_i;
      scl_q <= scl_m_q;
      scl_p_q <= scl_q;
      sda_m_q <= sda_i;
      sda_q <= sda_m_q;
      sda_p_q <= sda_q;
    end
  end

  assign start_w = scl_q && scl_p_q && sda_p_q && !sda_q;
  assign stop_w = scl_q && scl_p_q && !sda_p_q && sda_q;
  assign rise_w = scl_q && !scl_p_q;
  assign fall_w = !scl_q && scl_p_q;
  assign own_addr_w = ADDR_VARIANT_B ? `TARGET_ADDR_B : `TARGET_ADDR_A;

  // Read mux; reading the low data byte latches the high byte into a shadow
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    if (a == `REG_INFRARED_ROUTE_SELECT) begin
      read_reg = ir_sel_q;
    end else if (a == `REG_ENABLE) begin
      read_reg = enable_q;
    end else if (a == `REG_PERSIST) begin
      read_reg = persist_q;
    end else if (a == `REG_AUX) begin
      read_reg = aux_q;
    end else if (a == `REG_THRESH_LOW_L) begin
      read_reg = thr_low_q[7:0];
    end else if (a == `REG_THRESH_LOW_H) begin
      read_reg = thr_low_q[15:8];
    end else if (a == `REG_THRESH_HIGH_L) begin
      read_reg = thr_high_q[7:0];
    end else if (a == `REG_THRESH_HIGH_H) begin
      read_reg = thr_high_q[15:8];
    end else if (a == `REG_STATUS) begin
      read_reg = {sat_q, 2'h0, thr_irq_q | force_q, 3'h0, valid_q};
    end else if (a == `REG_CLEAR_DATA_L) begin
      read_reg = clear_data_q[7:0];
    end else if (a == `REG_CLEAR_DATA_H) begin
      read_reg = shadow_q;
    end else begin
      read_reg = 8'h00; // Unmapped reads return zero
    end
  endfunction : read_reg

  // Bus engine: address, register pointer, then data bytes with auto-increment
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q <= sensor_irq_pkg::ST_IDLE;
      bit_q <= 3'h0;
      shift_q <= `RESET_BYTE;
      ptr_q <= `RESET_BYTE;
      rdata_q <= `RESET_BYTE;
      rw_q <= 1'b0;
      sda_drv_q <= 1'b0;
      got_reg_q <= 1'b0;
    end else if (clk_en_i) begin
      if (start_w) begin
        state_q <= sensor_irq_pkg::ST_ADDR;
        bit_q <= 3'h7;
        sda_drv_q <= 1'b0;
        got_reg_q <= 1'b0; // The clock fall that follows a start carries no byte
      end else if (stop_w) begin
        state_q <= sensor_irq_pkg::ST_IDLE;
        sda_drv_q <= 1'b0;
      end else begin
        case (state_q)
          sensor_irq_pkg::ST_ADDR, sensor_irq_pkg::ST_REG, sensor_irq_pkg::ST_WDATA: begin
            if (rise_w) begin
              shift_q <= {shift_q[6:0], sda_q};
              bit_q <= bit_q - 3'h1;
              got_reg_q <= 1'b1;
            end
            if (fall_w && bit_q == 3'h7 && got_reg_q) begin
              // Full byte shifted in; decide ack
              got_reg_q <= 1'b0;
              if (state_q == sensor_irq_pkg::ST_ADDR) begin
                if (shift_q[7:1] == own_addr_w) begin
                  rw_q <= shift_q[0];
                  sda_drv_q <= 1'b1;
                  state_q <= sensor_irq_pkg::ST_ADDR_ACK;
                  rdata_q <= read_reg(ptr_q);
                end else begin
                  state_q <= sensor_irq_pkg::ST_IDLE;
                end
              end else if (state_q == sensor_irq_pkg::ST_REG) begin
                ptr_q <= shift_q;
                sda_drv_q <= 1'b1;
                state_q <= sensor_irq_pkg::ST_REG_ACK;
              end else begin
                sda_drv_q <= 1'b1;
                state_q <= sensor_irq_pkg::ST_WDATA_ACK;
              end
            end
          end
          sensor_irq_pkg::ST_ADDR_ACK, sensor_irq_pkg::ST_REG_ACK, sensor_irq_pkg::ST_WDATA_ACK: begin
            if (fall_w) begin
              bit_q <= 3'h7;
              if (state_q == sensor_irq_pkg::ST_ADDR_ACK && rw_q) begin
                state_q <= sensor_irq_pkg::ST_RDATA;
                sda_drv_q <= !rdata_q[7];
              end else begin
                sda_drv_q <= 1'b0;
                if (state_q == sensor_irq_pkg::ST_WDATA_ACK) begin
                  ptr_q <= ptr_q + 8'h01;
                end
                state_q <= (state_q == sensor_irq_pkg::ST_ADDR_ACK) ? sensor_irq_pkg::ST_REG
                                                                     : sensor_irq_pkg::ST_WDATA;
              end
            end
          end
          sensor_irq_pkg::ST_RDATA: begin
            if (fall_w) begin
              if (bit_q == 3'h0) begin
                sda_drv_q <= 1'b0;
                state_q <= sensor_irq_pkg::ST_RDATA_ACK;
              end else begin
                bit_q <= bit_q - 3'h1;
                sda_drv_q <= !rdata_q[bit_q - 3'h1];
              end
            end
          end
          sensor_irq_pkg::ST_RDATA_ACK: begin
            if (rise_w) begin
              // Host nack ends the read; ack continues with next register
              if (sda_q) begin
                state_q <= sensor_irq_pkg::ST_IDLE;
              end else begin
                ptr_q <= ptr_q + 8'h01;
                rdata_q <= read_reg(ptr_q + 8'h01);
              end
            end else if (fall_w) begin
              bit_q <= 3'h7;
              state_q <= sensor_irq_pkg::ST_RDATA;
              sda_drv_q <= !rdata_q[7];
            end
          end
          default: begin
            state_q <= sensor_irq_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Write strobe fires once per received data byte, any value
  assign wr_stb_w = clk_en_i && state_q == sensor_irq_pkg::ST_WDATA && fall_w && bit_q == 3'h7 && got_reg_q;
  assign wr_addr_w = ptr_q;

  // Configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ir_sel_q <= `RESET_BYTE;
      enable_q <= `RESET_BYTE;
      persist_q <= `RESET_BYTE;
      aux_q <= `RESET_BYTE;
      thr_low_q <= {`RESET_BYTE, `RESET_BYTE};
      thr_high_q <= {`RESET_BYTE, `RESET_BYTE};
    end else if (wr_stb_w) begin
      if (wr_addr_w == `REG_INFRARED_ROUTE_SELECT) begin
        ir_sel_q <= {shift_q[`BIT_IR_SELECT], 7'h00}; // Reserved bits kept zero
      end else if (wr_addr_w == `REG_ENABLE) begin
        enable_q <= shift_q;
      end else if (wr_addr_w == `REG_PERSIST) begin
        persist_q <= {4'h0, shift_q[3:0]};
      end else if (wr_addr_w == `REG_AUX) begin
        aux_q <= shift_q;
      end else if (wr_addr_w == `REG_THRESH_LOW_L) begin
        thr_low_q[7:0] <= shift_q;
      end else if (wr_addr_w == `REG_THRESH_LOW_H) begin
        thr_low_q[15:8] <= shift_q;
      end else if (wr_addr_w == `REG_THRESH_HIGH_L) begin
        thr_high_q[7:0] <= shift_q;
      end else if (wr_addr_w == `REG_THRESH_HIGH_H) begin
        thr_high_q[15:8] <= shift_q;
      end
    end
  end

  assign converter_enable_o = enable_q[`BIT_CONVERTER_ENABLE];
  assign chan_w = ir_sel_q[`BIT_IR_SELECT] ? sample_i.infrared_count : sample_i.clear_count;
  assign out_range_w = (chan_w < thr_low_q) || (chan_w > thr_high_q);

  // Persistence field to required consecutive count; zero means every valid sample
  function automatic logic [5:0] persist_need(input logic [3:0] f);
    if (f < 4'h4) begin
      persist_need = {2'h0, f};
    end else begin
      persist_need = 6'((f - 4'h3) * 5);
    end
  endfunction : persist_need

  assign thr_event_w = sample_valid_i && converter_enable_o && enable_q[`BIT_THRESH_IRQ_ENABLE] &&
                       (persist_q[3:0] == 4'h0 ||
                        (out_range_w && {1'b0, out_cnt_q} + 7'h01 >= {1'b0, persist_need(persist_q[3:0])}));

  // Data capture, shadow and persistence counter
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      clear_data_q <= {`RESET_BYTE, `RESET_BYTE};
      shadow_q <= `RESET_BYTE;
      out_cnt_q <= `PERSIST_ZERO;
      valid_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!converter_enable_o) begin
        valid_q <= 1'b0;
        out_cnt_q <= `PERSIST_ZERO;
      end else if (sample_valid_i) begin
        clear_data_q <= chan_w;
        valid_q <= 1'b1;
        out_cnt_q <= out_range_w ? ((out_cnt_q == 6'h3f) ? out_cnt_q : out_cnt_q + 6'h01) : `PERSIST_ZERO;
      end
      if (state_q == sensor_irq_pkg::ST_ADDR_ACK && fall_w && rw_q && ptr_q == `REG_CLEAR_DATA_L) begin
        shadow_q <= clear_data_q[15:8];
      end else if (state_q == sensor_irq_pkg::ST_RDATA_ACK && rise_w && !sda_q &&
                   ptr_q == `REG_CLEAR_DATA_H - 8'h02) begin
        shadow_q <= clear_data_q[15:8];
      end
    end
  end

  // Interrupt sources; a new event in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sat_q <= 1'b0;
      thr_irq_q <= 1'b0;
      force_q <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_stb_w && wr_addr_w == `REG_FORCE_INTERRUPT_COMMAND) begin
        force_q <= 1'b1;
      end else if (wr_stb_w && wr_addr_w == `REG_ALL_IRQ_CLEAR) begin
        force_q <= 1'b0;
      end
      if (thr_event_w) begin
        thr_irq_q <= 1'b1;
      end else if (wr_stb_w && (wr_addr_w == `REG_CLEAR_CHANNEL_IRQ_CLEAR || wr_addr_w == `REG_ALL_IRQ_CLEAR)) begin
        thr_irq_q <= 1'b0;
      end
      if (sample_valid_i && converter_enable_o && sample_i.saturated) begin
        sat_q <= 1'b1;
      end else if (!converter_enable_o ||
                   (wr_stb_w && (wr_addr_w == `REG_CLEAR_CHANNEL_IRQ_CLEAR || wr_addr_w == `REG_ALL_IRQ_CLEAR))) begin
        sat_q <= 1'b0;
      end
    end
  end

  // Open-drain pins: only ever pulled low, pull-ups give the high level
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_drv_q;
  assign int_n_o = 1'b0;
  assign int_n_oe_o = force_q || thr_irq_q || (sat_q && aux_q[`BIT_SAT_IRQ_ENABLE]);
endmodule : sensor_irq_clear_and_ir_select

// ---- sensor_irq_consts.svh ----
// Register offsets, field positions, bus addresses and reset values of the sensor interrupt block
`ifndef SENSOR_IRQ_CONSTS_SVH
`define SENSOR_IRQ_CONSTS_SVH
`define REG_INFRARED_ROUTE_SELECT 8'hc0
`define REG_FORCE_INTERRUPT_COMMAND 8'he4
`define REG_CLEAR_CHANNEL_IRQ_CLEAR 8'he6
`define REG_ALL_IRQ_CLEAR 8'he7
`define REG_ENABLE 8'h80
`define REG_PERSIST 8'h8c
`define REG_AUX 8'h90
`define REG_STATUS 8'h93
`define REG_THRESH_LOW_L 8'h84
`define REG_THRESH_LOW_H 8'h85
`define REG_THRESH_HIGH_L 8'h86
`define REG_THRESH_HIGH_H 8'h87
`define REG_CLEAR_DATA_L 8'h94
`define REG_CLEAR_DATA_H 8'h95
`define BIT_IR_SELECT 7
`define BIT_CONVERTER_ENABLE 1
`define BIT_THRESH_IRQ_ENABLE 4
`define BIT_SAT_IRQ_ENABLE 5
`define BIT_STATUS_SAT 7
`define BIT_STATUS_THRESH 4
`define BIT_STATUS_VALID 0
`define TARGET_ADDR_A 7'h39
`define TARGET_ADDR_B 7'h29
`define RESET_BYTE 8'h00
`define PERSIST_ZERO 6'h00
`endif

// ---- sensor_irq_pkg.sv ----
// Types shared by the sensor interrupt block
package sensor_irq_pkg;
  // One finished conversion from the analog front end
  typedef struct packed {
    logic [15:0] clear_count;
    logic [15:0] infrared_count;
    logic saturated;
  } sample_t;
  // Bus engine phases
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } bus_state_t;
endpackage : sensor_irq_pkg

// ---- sensor_irq_host_model.sv ----
// Bus controller model that plays the host processor on SCL and SDA
`timescale 1ns/1ps
module sensor_irq_host_model (
  input wire logic sys_clk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_oe_o
);
  localparam int HALF = 12; // SCL phase in clocks, well above the minimum of 4
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : hold
  // Data moves only mid low phase, so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    scl_o = 1'b0;
    hold(HALF / 2);
    sda_oe_o = !b;
    hold(HALF / 2);
    scl_o = 1'b1;
    hold(HALF);
    r = sda_line_i;
  endtask : bit_io
  task automatic start();
    sda_oe_o = 1'b1;
    hold(HALF);
  endtask : start
  task automatic stop();
    scl_o = 1'b0;
    hold(HALF / 2);
    sda_oe_o = 1'b1;
    hold(HALF / 2);
    scl_o = 1'b1;
    hold(HALF);
    sda_oe_o = 1'b0;
    hold(HALF);
  endtask : stop
  // Eight bits then the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [7:0] tx, input logic ak_in, output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ak_in, ak);
  endtask : xfer
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic k1, k2, k3;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, k1);
    xfer(a, 1'b1, rx, k2);
    xfer(d, 1'b1, rx, k3);
    stop();
    ok = !k1 && !k2 && !k3;
  endtask : write_reg
  // Pointer set in one frame, one byte fetched with a final not-acknowledge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] rx;
    logic k;
    start();
    xfer({7'h39, 1'b0}, 1'b1, rx, k);
    xfer(a, 1'b1, rx, k);
    stop();
    start();
    xfer({7'h39, 1'b1}, 1'b1, rx, k);
    xfer(8'hff, 1'b1, d, k);
    stop();
  endtask : read_reg
endmodule : sensor_irq_host_model

// ---- sensor_irq_checker.sv ----
// Port-level assertions for the sensor interrupt block
`timescale 1ns/1ps
module sensor_irq_checker (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic int_n_o,
  input wire logic int_n_oe_o,
  input wire logic sample_valid_i,
  input wire sensor_irq_pkg::sample_t sample_i,
  input wire logic converter_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic scl_prev_q;
  logic [3:0] since_fall_q;
  // Cycles since SCL fell; every bus-made change must land shortly after one
  always_ff @(posedge sys_clk_i) begin
    scl_prev_q <= scl_i;
    if (reset_i || (scl_prev_q && !scl_i)) since_fall_q <= 4'h0;
    else if (since_fall_q != 4'hf) since_fall_q <= since_fall_q + 4'h1;
  end
  AST_OPEN_DRAIN: assert property (!sda_o && !int_n_o) else $error("pin drives high");
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset_i |=> !sda_oe_o && !int_n_oe_o && !converter_enable_o)
    else $error("outputs active after reset");
  AST_SDA_MOVES: assert property ($changed(sda_oe_o) |-> !scl_i && since_fall_q <= 4'ha)
    else $error("data line moved outside clock low");
  AST_INT_RISE: assert property ($rose(int_n_oe_o) |-> since_fall_q <= 4'ha || $past(sample_valid_i)
    || $past(sample_valid_i, 2)) else $error("interrupt without cause");
  AST_INT_FALL: assert property ($fell(int_n_oe_o) |-> since_fall_q <= 4'ha)
    else $error("interrupt dropped without clear write");
  AST_CONV: assert property ($changed(converter_enable_o) |-> since_fall_q <= 4'ha)
    else $error("converter enable moved without write");
  AST_FREEZE: assert property (!clk_en_i && !reset_i |=> $stable(int_n_oe_o) && $stable(sda_oe_o)
    && $stable(converter_enable_o)) else $error("state moved while frozen");
  AST_INT_STANDS: assert property (int_n_oe_o && since_fall_q > 4'ha |=> int_n_oe_o)
    else $error("interrupt released while pending");
  COV_BUS_RISE: cover property ($rose(int_n_oe_o) && since_fall_q <= 4'ha);
  COV_SAMPLE_RISE: cover property (sample_valid_i ##[1:2] $rose(int_n_oe_o));
  COV_FALL: cover property ($fell(int_n_oe_o));
endmodule : sensor_irq_checker
bind sensor_irq_clear_and_ir_select sensor_irq_checker u_sensor_irq_checker (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
  .converter_enable_o(converter_enable_o));

// ---- sensor_irq_clear_and_ir_select_test.sv ----
// Self-checking bench for the sensor interrupt block driven by the host model
`timescale 1ns/1ps
module sensor_irq_clear_and_ir_select_test;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
  logic sys_clk_i, reset_i, clk_en_i, sample_valid_i, scl, host_sda_oe, ok;
  logic sda_o, sda_oe_o, int_n_o, int_n_oe_o, converter_enable_o;
  logic [7:0] rd;
  sensor_irq_pkg::sample_t sample_i;
  int errors, n_compared;
  wire sda_line = !(host_sda_oe || sda_oe_o); // Pull-up unless a party pulls low
  // Write, then read back; thresholds 0x0100..0x0200, persistence 2, converter on last
  row_t rows [9] = '{'{8'hc0, 8'h80, 8'h80}, '{8'h8c, 8'h02, 8'h02}, '{8'h84, 8'h00, 8'h00},
    '{8'h85, 8'h01, 8'h01}, '{8'h86, 8'h00, 8'h00}, '{8'h87, 8'h02, 8'h02}, '{8'h90, 8'h20, 8'h20},
    '{8'ha0, 8'h55, 8'h00}, '{8'h80, 8'h12, 8'h12}};
  sensor_irq_clear_and_ir_select u_sensor_irq_clear_and_ir_select (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o),
    .int_n_oe_o(int_n_oe_o), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .converter_enable_o(converter_enable_o));
  sensor_irq_host_model u_sensor_irq_host_model (.sys_clk_i(sys_clk_i), .sda_line_i(sda_line), .scl_o(scl),
    .sda_oe_o(host_sda_oe));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = !sys_clk_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_sensor_irq_host_model.write_reg(7'h39, a, d, ok);
    check("write ack", ok, 8'h01);
  endtask : wr
  task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
    u_sensor_irq_host_model.read_reg(a, rd);
    check("read", rd, exp);
  endtask : rdr
  task automatic send(input logic [15:0] c, input logic [15:0] ir, input logic sat);
    @(negedge sys_clk_i);
    sample_i = '{c, ir, sat};
    sample_valid_i = 1'b1;
    @(negedge sys_clk_i);
    sample_valid_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask : send
  task automatic pin(input logic exp);
    check("interrupt pin", int_n_oe_o, exp);
  endtask : pin
  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Watchdog sized well beyond the 57 bus frames of the run
  initial begin
    #600_000;
    errors++;
    report_and_stop();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    sample_valid_i = 1'b0;
    sample_i = '0;
    repeat (8) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    pin(1'b0);
    check("converter", converter_enable_o, 8'h00);
    rdr(8'hc0, 8'h00);
    u_sensor_irq_host_model.write_reg(7'h29, 8'he4, 8'h00, ok);
    check("foreign address ack", ok, 8'h00);
    pin(1'b0);
    wr(8'he4, 8'h00);
    pin(1'b1);
    wr(8'he6, 8'h00);
    pin(1'b1);
    wr(8'he7, 8'h00);
    pin(1'b0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdr(rows[i].a, rows[i].q);
    end
    check("converter", converter_enable_o, 8'h01);
    // A sample offered while frozen must not count toward persistence
    clk_en_i = 1'b0;
    send(16'h0050, 16'h0060, 1'b0);
    clk_en_i = 1'b1;
    send(16'h0050, 16'h0060, 1'b0);
    pin(1'b0);
    send(16'h0050, 16'h0060, 1'b0);
    pin(1'b1);
    rdr(8'h94, 8'h60);
    rdr(8'h95, 8'h00);
    wr(8'hc0, 8'h00);
    send(16'h0150, 16'h0160, 1'b0);
    rdr(8'h94, 8'h50);
    rdr(8'h95, 8'h01);
    wr(8'he6, 8'ha5);
    pin(1'b0);
    rdr(8'h93, 8'h01);
    send(16'h0150, 16'h0160, 1'b1);
    pin(1'b1);
    rdr(8'h93, 8'h81);
    wr(8'he6, 8'h00);
    rdr(8'h93, 8'h01);
    send(16'h0150, 16'h0160, 1'b1);
    wr(8'he4, 8'h00);
    wr(8'he7, 8'h00);
    pin(1'b0);
    rdr(8'h93, 8'h01);
    send(16'h0150, 16'h0160, 1'b1);
    wr(8'h80, 8'h10);
    check("converter", converter_enable_o, 8'h00);
    rdr(8'h93, 8'h00);
    pin(1'b0);
    report_and_stop();
  end
endmodule : sensor_irq_clear_and_ir_select_test
